// ### pcd_pkg.sv
// Constants for the page, update-control and serial clock-role register set
// Assumes an APB slave with 32-bit data and one register per aligned word
package pcd_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] PCD_IDX_PAGE = 8'h00;
  localparam logic [7:0] PCD_IDX_DSP = 8'h03;
  localparam logic [7:0] PCD_IDX_ROLE = 8'h0d;

  // ----------------------------------------------------------------
  // Page holding the update and role registers
  // ----------------------------------------------------------------
  localparam logic [7:0] PCD_PAGE_ZERO = 8'h00;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] PCD_RST_PAGE = 8'h00;
  localparam logic [7:0] PCD_RST_DSP = 8'h00;
  localparam logic [7:0] PCD_RST_ROLE = 8'h00;

  // ----------------------------------------------------------------
  // Writable bit masks (read-only reserved bits stay zero)
  // ----------------------------------------------------------------
  localparam logic [7:0] PCD_WMASK_DSP = 8'hef;
  localparam logic [7:0] PCD_WMASK_ROLE = 8'hdf;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int PCD_BIT_BLOCK_VOL = 1;
  localparam int PCD_BIT_ALLOW_BQ = 0;
  localparam int PCD_BIT_PRI_OVR = 7;
  localparam int PCD_BIT_SEC_OVR = 6;
  localparam int PCD_BIT_PRI_INT_FS = 2;
  localparam int PCD_BIT_SEC_INT_FS = 1;

  // ----------------------------------------------------------------
  // Bus access phases
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    PCD_IDLE = 3'b001,
    PCD_SETUP = 3'b010,
    PCD_ACCESS = 3'b100
  } pcd_phase_type;

endpackage : pcd_pkg

// ### pcd_role_ctrl.sv
// Controller/target pin-direction logic for one audio serial interface
// Assumes the role-configuration bit comes from elsewhere in the device
`timescale 1ns/1ps
module pcd_role_ctrl
  import pcd_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic role_config,
  input wire logic role_override,
  input wire logic internal_frame_sync,
  output logic bclk_oe,
  output logic frame_sync_pin_oe,
  output logic auto_detect_enable,
  output logic internal_frame_sync_active
);

  typedef struct packed {
    logic bclk_oe;
    logic fs_oe;
    logic auto_det;
    logic int_fs;
  } pcd_role_state_type;

  pcd_role_state_type state;
  pcd_role_state_type next_state;

  // ----------------------------------------------------------------
  // Direction decode
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    if (role_override) begin
      next_state.bclk_oe = role_config;
      next_state.fs_oe = ~role_config;
    end else begin
      next_state.bclk_oe = role_config;
      next_state.fs_oe = role_config;
    end
    next_state.auto_det = ~role_override;
    next_state.int_fs = role_config & internal_frame_sync;
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign bclk_oe = state.bclk_oe;
  assign frame_sync_pin_oe = state.fs_oe;
  assign auto_detect_enable = state.auto_det;
  assign internal_frame_sync_active = state.int_fs;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_follow_role: assert property (@(posedge clock) disable iff (sys_rst)
    !role_override |=> (bclk_oe == $past(role_config)) && (frame_sync_pin_oe == bclk_oe))
    else $error("role not followed without override");
  a_auto_detect_off: assert property (@(posedge clock) disable iff (sys_rst)
    role_override |=> !auto_detect_enable)
    else $error("auto detect left on under override");
  a_override_target: assert property (@(posedge clock) disable iff (sys_rst)
    role_override && !role_config |=> !bclk_oe && frame_sync_pin_oe)
    else $error("override target directions wrong");
  a_override_ctrl: assert property (@(posedge clock) disable iff (sys_rst)
    role_override && role_config |=> bclk_oe && !frame_sync_pin_oe)
    else $error("override controller directions wrong");
  a_int_frame_sync_pin_sel: assert property (@(posedge clock) disable iff (sys_rst)
    role_config && internal_frame_sync |=> internal_frame_sync_active)
    else $error("internal frame sync not selected");

endmodule : pcd_role_ctrl

// ### pcd_config_regs.sv
// Page select, runtime update control and serial clock-role registers
// Assumes an APB master on the same clock; pins are steered by two role blocks
//
// Contract
// - An 8-bit page-select register sits at index 0x0 on every page.
// - The page-select value is the page number directly, 0 to 255.
// - Bit 1 at index 0x3 set blocks volume changes while the ADC is powered.
// - Bit 0 at index 0x3 set lets biquad changes apply on the fly.
// - Bit 7 at index 0xD clear: primary role follows its role bit.
// - Bit 6 at index 0xD clear: secondary role follows its role bit.
// - A set role override turns off clock auto detection for that interface.
// - Override with role bit 0: bit clock is input, frame sync is output.
// - Override with role bit 1: bit clock is output, frame sync is input.
// - Bit 2 at index 0xD: primary controller uses internal frame sync.
// - Bit 1 at index 0xD: secondary controller uses internal frame sync.
`timescale 1ns/1ps
module pcd_config_regs
  import pcd_pkg::*;
#(
  parameter int ADDR_WIDTH = 12
)
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_WIDTH-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [7:0] active_page,
  input wire logic adc_powered,
  input wire logic volume_change_req,
  output logic volume_change_apply,
  input wire logic biquad_change_req,
  output logic biquad_change_apply,
  output logic block_runtime_volume_change,
  output logic allow_runtime_biquad_change,
  input wire logic primary_role_config,
  input wire logic secondary_role_config,
  output logic primary_bclk_oe,
  output logic primary_frame_sync_pin_oe,
  output logic primary_auto_detect_enable,
  output logic primary_internal_frame_sync,
  output logic secondary_bclk_oe,
  output logic secondary_frame_sync_pin_oe,
  output logic secondary_auto_detect_enable,
  output logic secondary_internal_frame_sync
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] reg_index(input logic [ADDR_WIDTH-1:0] addr);
    reg_index = addr[9:2];
  endfunction : reg_index

  function automatic logic addr_legal(input logic [ADDR_WIDTH-1:0] addr);
    addr_legal = (addr[1:0] == 2'b00) && (addr[ADDR_WIDTH-1:10] == '0);
  endfunction : addr_legal

  function automatic logic [7:0] masked_write(input logic [7:0] old_value,
                                              input logic [7:0] new_value,
                                              input logic [7:0] mask);
    masked_write = (old_value & ~mask) | (new_value & mask);
  endfunction : masked_write

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    pcd_phase_type phase;
    logic [7:0] page;
    logic [7:0] dsp;
    logic [7:0] role;
    logic [31:0] rdata;
    logic vol_apply;
    logic bq_apply;
  } pcd_regs_state_type;

  pcd_regs_state_type state;
  pcd_regs_state_type next_state;

  logic [7:0] idx;
  logic legal;
  logic hit_page;
  logic hit_dsp;
  logic hit_role;
  logic mapped;
  logic setup_cycle;
  logic access_cycle;
  logic wr_fire;
  logic wr_lane;
  logic [7:0] wr_byte;
  logic [7:0] rd_byte;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  assign idx = reg_index(paddr);
  assign legal = addr_legal(paddr);
  assign hit_page = legal && (idx == PCD_IDX_PAGE);
  assign hit_dsp = legal && (state.page == PCD_PAGE_ZERO) && (idx == PCD_IDX_DSP);
  assign hit_role = legal && (state.page == PCD_PAGE_ZERO) && (idx == PCD_IDX_ROLE);
  assign mapped = hit_page || hit_dsp || hit_role;

  assign setup_cycle = psel && !penable;
  assign access_cycle = psel && penable;
  assign wr_fire = access_cycle && pwrite && mapped;
  assign wr_lane = pstrb[0];
  assign wr_byte = pwdata[7:0];

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always_comb begin
    rd_byte = 8'h00;
    if (hit_page) begin
      rd_byte = state.page;
    end else if (hit_dsp) begin
      rd_byte = state.dsp;
    end else if (hit_role) begin
      rd_byte = state.role;
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    unique case (state.phase)
      PCD_IDLE: begin
        if (setup_cycle) begin
          next_state.phase = PCD_SETUP;
        end
      end
      PCD_SETUP: begin
        if (access_cycle) begin
          next_state.phase = PCD_ACCESS;
        end else if (!psel) begin
          next_state.phase = PCD_IDLE;
        end
      end
      PCD_ACCESS: begin
        if (setup_cycle) begin
          next_state.phase = PCD_SETUP;
        end else begin
          next_state.phase = PCD_IDLE;
        end
      end
      default: begin
        next_state.phase = PCD_IDLE;
      end
    endcase

    // Read data captured in the setup cycle
    if (setup_cycle && !pwrite) begin
      next_state.rdata = {24'h000000, rd_byte};
    end

    if (wr_fire && wr_lane) begin
      if (hit_page) begin
        next_state.page = wr_byte;
      end
      if (hit_dsp) begin
        next_state.dsp = masked_write(state.dsp, wr_byte, PCD_WMASK_DSP);
      end
      if (hit_role) begin
        next_state.role = masked_write(state.role, wr_byte, PCD_WMASK_ROLE);
      end
    end

    next_state.vol_apply = volume_change_req &&
                           !(state.dsp[PCD_BIT_BLOCK_VOL] && adc_powered);
    next_state.bq_apply = biquad_change_req && state.dsp[PCD_BIT_ALLOW_BQ];
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state.phase <= PCD_IDLE;
      state.page <= PCD_RST_PAGE;
      state.dsp <= PCD_RST_DSP;
      state.role <= PCD_RST_ROLE;
      state.rdata <= 32'h00000000;
      state.vol_apply <= 1'b0;
      state.bq_apply <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata = state.rdata;
  assign pready = 1'b1;
  assign pslverr = access_cycle && !mapped;
  assign active_page = state.page;
  assign volume_change_apply = state.vol_apply;
  assign biquad_change_apply = state.bq_apply;
  assign block_runtime_volume_change = state.dsp[PCD_BIT_BLOCK_VOL];
  assign allow_runtime_biquad_change = state.dsp[PCD_BIT_ALLOW_BQ];

  // ----------------------------------------------------------------
  // Serial interface roles
  // ----------------------------------------------------------------
  // primary role
  pcd_role_ctrl u_primary (
    .clock(clock),
    .sys_rst(sys_rst),
    .role_config(primary_role_config),
    .role_override(state.role[PCD_BIT_PRI_OVR]),
    .internal_frame_sync(state.role[PCD_BIT_PRI_INT_FS]),
    .bclk_oe(primary_bclk_oe),
    .frame_sync_pin_oe(primary_frame_sync_pin_oe),
    .auto_detect_enable(primary_auto_detect_enable),
    .internal_frame_sync_active(primary_internal_frame_sync)
  );

  pcd_role_ctrl u_secondary (
    .clock(clock),
    .sys_rst(sys_rst),
    .role_config(secondary_role_config),
    .role_override(state.role[PCD_BIT_SEC_OVR]),
    .internal_frame_sync(state.role[PCD_BIT_SEC_INT_FS]),
    .bclk_oe(secondary_bclk_oe),
    .frame_sync_pin_oe(secondary_frame_sync_pin_oe),
    .auto_detect_enable(secondary_auto_detect_enable),
    .internal_frame_sync_active(secondary_internal_frame_sync)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_page_write: assert property (@(posedge clock) disable iff (sys_rst)
    wr_fire && wr_lane && hit_page |=> active_page == $past(wr_byte))
    else $error("page select not written");
  a_page_hold: assert property (@(posedge clock) disable iff (sys_rst)
    !(wr_fire && hit_page) |=> $stable(active_page))
    else $error("page changed without a write");
  a_page_decode: assert property (@(posedge clock) disable iff (sys_rst)
    access_cycle && legal && (idx == PCD_IDX_DSP) && (active_page != PCD_PAGE_ZERO)
    |-> pslverr)
    else $error("off-page access decoded as page zero");
  a_volume_block: assert property (@(posedge clock) disable iff (sys_rst)
    volume_change_req && block_runtime_volume_change && adc_powered
    |=> !volume_change_apply)
    else $error("volume change applied while blocked");
  a_volume_pass: assert property (@(posedge clock) disable iff (sys_rst)
    volume_change_req && !block_runtime_volume_change |=> volume_change_apply)
    else $error("volume change dropped while allowed");
  a_biquad_gate: assert property (@(posedge clock) disable iff (sys_rst)
    biquad_change_req |=> biquad_change_apply == $past(allow_runtime_biquad_change))
    else $error("biquad update gate wrong");
  a_secondary_follow: assert property (@(posedge clock) disable iff (sys_rst)
    !state.role[PCD_BIT_SEC_OVR] ##1 !state.role[PCD_BIT_SEC_OVR]
    |-> secondary_bclk_oe == $past(secondary_role_config))
    else $error("secondary role not followed");
  a_secondary_frame_sync_pin: assert property (@(posedge clock) disable iff (sys_rst)
    secondary_role_config && state.role[PCD_BIT_SEC_INT_FS]
    |=> secondary_internal_frame_sync)
    else $error("secondary internal frame sync not selected");
  a_read_data: assert property (@(posedge clock) disable iff (sys_rst)
    setup_cycle && !pwrite && hit_page ##1 access_cycle |-> prdata[7:0] == $past(active_page))
    else $error("page read back wrong");
  a_page_reach: assert property (@(posedge clock) disable iff (sys_rst)
    access_cycle && legal && (idx == PCD_IDX_PAGE) |-> !pslverr)
    else $error("page select not reachable");
  a_role_decode: assert property (@(posedge clock) disable iff (sys_rst)
    access_cycle && legal && (idx == PCD_IDX_ROLE) && (active_page != PCD_PAGE_ZERO)
    |-> pslverr)
    else $error("off-page role access decoded as page zero");
  a_error_illegal: assert property (@(posedge clock) disable iff (sys_rst)
    access_cycle && !legal |-> pslverr)
    else $error("illegal address accepted");
  a_volume_idle: assert property (@(posedge clock) disable iff (sys_rst)
    volume_change_req && !adc_powered |=> volume_change_apply)
    else $error("volume change dropped with the ADC off");
  a_dsp_hold: assert property (@(posedge clock) disable iff (sys_rst)
    !(wr_fire && hit_dsp) |=> $stable(allow_runtime_biquad_change))
    else $error("update control changed without a write");
  a_role_hold: assert property (@(posedge clock) disable iff (sys_rst)
    !(wr_fire && hit_role) |=> $stable(state.role))
    else $error("role control changed without a write");
  a_primary_follow: assert property (@(posedge clock) disable iff (sys_rst)
    !state.role[PCD_BIT_PRI_OVR] ##1 !state.role[PCD_BIT_PRI_OVR]
    |-> primary_bclk_oe == $past(primary_role_config))
    else $error("primary role not followed");
  a_primary_frame_sync_pin: assert property (@(posedge clock) disable iff (sys_rst)
    primary_role_config && state.role[PCD_BIT_PRI_INT_FS]
    |=> primary_internal_frame_sync)
    else $error("primary internal frame sync not selected");
  a_external_frame_sync_pin: assert property (@(posedge clock) disable iff (sys_rst)
    !state.role[PCD_BIT_PRI_INT_FS] |=> !primary_internal_frame_sync)
    else $error("external frame sync not kept");

endmodule : pcd_config_regs

// ### page_clock_dsp_config_regs_bench.sv
// Self-checking bench for the page, update-control and clock-role registers
// Assumes pcd_pkg and pcd_config_regs compiled first; bench acts as APB master
`timescale 1ns/1ps
module page_clock_dsp_config_regs_bench;
  import pcd_pkg::*;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  typedef struct packed {
    logic w;
    logic [11:0] a;
    logic [31:0] d;
    logic [3:0] s;
    logic [31:0] exp;
    logic err;
  } pcd_row_type;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [3:0] pstrb = 4'hf;
  logic [31:0] prdata;
  logic pready, pslverr;
  logic [7:0] active_page;
  logic adc_powered = 1'b0, volume_change_req = 1'b0, biquad_change_req = 1'b0;
  logic volume_change_apply, biquad_change_apply;
  logic block_runtime_volume_change, allow_runtime_biquad_change;
  logic primary_role_config = 1'b0, secondary_role_config = 1'b0;
  logic p_bclk, p_fs, p_auto, p_int, s_bclk, s_fs, s_auto, s_int;
  int err_total = 0;
  int n_tests = 0;
  int cyc = 0;
  logic [31:0] rd;
  logic er;
  pcd_row_type rows [0:14];

  pcd_config_regs i_dut (.clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .active_page(active_page),
    .adc_powered(adc_powered), .volume_change_req(volume_change_req),
    .volume_change_apply(volume_change_apply), .biquad_change_req(biquad_change_req),
    .biquad_change_apply(biquad_change_apply),
    .block_runtime_volume_change(block_runtime_volume_change),
    .allow_runtime_biquad_change(allow_runtime_biquad_change),
    .primary_role_config(primary_role_config), .secondary_role_config(secondary_role_config),
    .primary_bclk_oe(p_bclk), .primary_frame_sync_pin_oe(p_fs),
    .primary_auto_detect_enable(p_auto), .primary_internal_frame_sync(p_int),
    .secondary_bclk_oe(s_bclk), .secondary_frame_sync_pin_oe(s_fs),
    .secondary_auto_detect_enable(s_auto), .secondary_internal_frame_sync(s_int));

  // ----------------------------------------------------------------
  // Clock and timeout
  // ----------------------------------------------------------------
  initial begin
    forever #20 clock = ~clock;
  end

  always @(posedge clock) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      report_and_stop();
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Expected {bclk_oe, frame_sync_oe, auto_detect, internal_fs}
  function automatic logic [3:0] role_exp(input logic ovr, input logic role, input logic fs);
    if (!ovr) return {role, role, 1'b1, role & fs};
    return {role, ~role, 1'b0, role & fs};
  endfunction : role_exp

  task automatic report_and_stop();
    $display("Errors %0d of %0d checks", err_total, n_tests);
    if (err_total == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : report_and_stop

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rows = '{
      '{1'b1, 12'h00c, 32'h00000003, 4'hf, 32'h0, 1'b0},
      '{1'b0, 12'h00c, 32'h0, 4'hf, 32'h00000003, 1'b0},
      '{1'b1, 12'h034, 32'h000000c6, 4'hf, 32'h0, 1'b0},
      '{1'b0, 12'h034, 32'h0, 4'hf, 32'h000000c6, 1'b0},
      '{1'b1, 12'h000, 32'h000000a5, 4'hf, 32'h0, 1'b0},
      '{1'b0, 12'h000, 32'h0, 4'hf, 32'h000000a5, 1'b0},
      '{1'b0, 12'h00c, 32'h0, 4'hf, 32'h0, 1'b1},
      '{1'b1, 12'h034, 32'h0, 4'hf, 32'h0, 1'b1},
      '{1'b1, 12'h000, 32'h0, 4'hf, 32'h0, 1'b0},
      '{1'b0, 12'h034, 32'h0, 4'hf, 32'h000000c6, 1'b0},
      '{1'b0, 12'h008, 32'h0, 4'hf, 32'h0, 1'b1},
      '{1'b0, 12'h00d, 32'h0, 4'hf, 32'h0, 1'b1},
      '{1'b0, 12'h400, 32'h0, 4'hf, 32'h0, 1'b1},
      '{1'b1, 12'h00c, 32'h00000002, 4'hf, 32'h0, 1'b0},
      '{1'b1, 12'h00c, 32'h00000001, 4'h0, 32'h00000002, 1'b0}};
    repeat (12) @(posedge clock);
    sys_rst <= 1'b0;
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d, rows[i].s);
      chk({31'h0, er}, {31'h0, rows[i].err});
      if (!rows[i].w) chk(rd, rows[i].exp);
    end
    apb(1'b0, 12'h00c, 32'h0, 4'hf);
    chk(rd, 32'h00000002);
    // Page values 0, 85, 170 and 255 decode straight through
    for (int p = 0; p < 256; p += 85) begin
      apb(1'b1, 12'h000, p, 4'hf);
      @(posedge clock);
      #1 chk({24'h0, active_page}, p);
    end
    apb(1'b1, 12'h000, 32'h0, 4'hf);
    // Volume and biquad gating, every combination
    for (int k = 0; k < 8; k++) begin
      apb(1'b1, 12'h00c, {30'h0, k[2], k[1]}, 4'hf);
      @(posedge clock);
      adc_powered <= k[0];
      volume_change_req <= 1'b1;
      biquad_change_req <= 1'b1;
      @(posedge clock);
      volume_change_req <= 1'b0;
      biquad_change_req <= 1'b0;
      #1 chk({30'h0, block_runtime_volume_change, allow_runtime_biquad_change}, k[2:1]);
      chk({31'h0, volume_change_apply}, {31'h0, ~(k[2] & k[0])});
      chk({31'h0, biquad_change_apply}, {31'h0, k[1]});
      @(posedge clock);
      #1 chk({30'h0, volume_change_apply, biquad_change_apply}, 32'h0);
    end
    // Role override, role bit and internal frame sync, both interfaces
    for (int k = 0; k < 8; k++) begin
      apb(1'b1, 12'h034, {24'h0, k[2], ~k[2], 3'b000, k[0], ~k[0], 1'b0}, 4'hf);
      @(posedge clock);
      primary_role_config <= k[1];
      secondary_role_config <= ~k[1];
      repeat (2) @(posedge clock);
      #1 chk({p_bclk, p_fs, p_auto, p_int}, role_exp(k[2], k[1], k[0]));
      chk({s_bclk, s_fs, s_auto, s_int}, role_exp(~k[2], ~k[1], ~k[0]));
    end
    // Reset in mid-run clears every register
    apb(1'b1, 12'h000, 32'h00000033, 4'hf);
    @(posedge clock);
    sys_rst <= 1'b1;
    primary_role_config <= 1'b0;
    secondary_role_config <= 1'b0;
    repeat (12) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clock);
    #1 chk({24'h0, active_page}, {24'h0, PCD_RST_PAGE});
    chk({p_bclk, p_fs, p_auto, p_int, s_bclk, s_fs, s_auto, s_int}, 32'h22);
    apb(1'b0, 12'h00c, 32'h0, 4'hf);
    chk(rd, {24'h0, PCD_RST_DSP});
    apb(1'b0, 12'h034, 32'h0, 4'hf);
    chk(rd, {24'h0, PCD_RST_ROLE});
    report_and_stop();
  end

endmodule : page_clock_dsp_config_regs_bench
